// [sprf_pkg.sv]
// package for the serial port, ready and fault pin block
// assumes a 20 MHz system clock and a host-driven serial clock
package sprf_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned DATA_WIDTH = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned REG_COUNT = 8;
	localparam int unsigned REG_ADDR_WIDTH = 3;
	// command byte layout: bit 6 read, bits 2..0 register select
	localparam int unsigned CMD_READ_BIT = 6;
	localparam int unsigned CMD_SEL_LSB = 0;
	// register indices
	localparam logic [2:0] STATUS_INDEX = 3'h0;
	localparam logic [2:0] MODE_INDEX = 3'h1;
	localparam logic [2:0] IOCTL_INDEX = 3'h2;
	localparam logic [2:0] DATA_INDEX = 3'h3;
	// pin io control register fields
	localparam int unsigned IOCTL_FAULT_MODE_LSB = 0;
	localparam int unsigned IOCTL_FAULT_LEVEL_BIT = 2;
	localparam int unsigned IOCTL_POWER_DOWN_SWITCH_CONTROL_BIT = 3;
	// converter mode register field
	localparam int unsigned MODE_CLKSEL_LSB = 2;
	// status register flags
	localparam int unsigned STATUS_EXT_FAULT_BIT = 5;
	localparam logic [7:0] STATUS_ERROR_MASK = 8'h70;
	// reset values
	localparam logic [7:0] IOCTL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// fault pin modes
	typedef enum logic [1:0] {
		FAULT_INPUT = 2'h0,
		FAULT_OPEN_DRAIN = 2'h1,
		FAULT_DRIVEN = 2'h2
	} sprf_fault_mode_type;
	// clock pin configuration
	typedef enum logic [1:0] {
		CLKPIN_INTERNAL = 2'h0,
		CLKPIN_OUTPUT = 2'h1,
		CLKPIN_INPUT = 2'h2,
		CLKPIN_CRYSTAL = 2'h3
	} sprf_clk_sel_type;
	// link-side transfer states
	typedef enum logic [2:0] {
		LINK_CMD = 3'h1,
		LINK_READ = 3'h2,
		LINK_WRITE = 3'h4
	} sprf_link_state_type;
endpackage

// [sprf_top.sv]
// serial port, ready indicator, fault pin, switch and clock pin control
// assumes the host owns sclk_i and csn_i; conversions arrive as clk_i-synchronous pulses on conv_done_i
// What this block does
// - output bit changes after each falling serial clock edge
// - chip select high puts the data/ready pin in high impedance
// - selected and idle, the pin shows ready, low when a result is new
// - unread result drives ready high again at the next update
// - input bits are captured on the rising serial clock edge
// - written bytes go to the register named by the select field, except the status and data registers
// - reads load the output shifter from any addressed register
// - works with chip select tied low, three wires only
// - fault input mode, low on the pin sets the external fault flag
// - open-drain mode pulls the fault pin low when any error flag is set
// - open-drain mode never drives the fault pin high
// - driven mode makes the fault pin follow the level bit
// - driven mode drives the fault pin both high and low
// - power-down switch follows its control bit
// - clock pin role follows the clock source select field
`timescale 1ns/10ps
`default_nettype none

// small fifo carrying written words from link domain
module sprf_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] fill;
	assign fill = wr_ptr - rd_ptr;
	// full once the pointers are a whole depth apart
	assign in_ready_o = (fill != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid_o = (fill != '0);
	assign out_data_o = mem[rd_ptr[AW-1:0]];
	// pointers and storage
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid_i && in_ready_o) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid_o && out_ready_i) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (in_valid_i && in_ready_o) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end
endmodule // sprf_fifo

module sprf_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic csn_i,
	input wire logic din_i,
	output logic dout_o,
	output logic dout_oe_o,
	input wire logic fault_pin_i,
	output logic fault_pin_o,
	output logic fault_pin_oe_o,
	input wire logic conv_done_i,
	input wire logic [7:0] conv_data_i,
	input wire logic [2:0] error_flags_i,
	output logic power_down_switch_control_o,
	output logic [1:0] clock_pin_role_o,
	output logic [7:0] status_o
);
	logic [7:0] regs [sprf_pkg::REG_COUNT];
	logic [7:0] status_reg;
	// ready and fault state, read by the status register
	logic ready_n;
	logic ext_fault;

	// link domain: shift registers and transfer state
	logic rst_sync_m;
	logic rst_sync_n;
	sprf_pkg::sprf_link_state_type link_state;
	logic [2:0] bit_cnt;
	logic [7:0] in_shift;
	logic [7:0] out_shift;
	logic [2:0] sel;
	logic wr_tgl;
	logic [10:0] wr_word;
	logic rd_req_tgl;
	logic dout_bit;
	logic [7:0] snap [sprf_pkg::REG_COUNT];
	logic [7:0] next_byte;
	assign next_byte = {in_shift[6:0], din_i};

	// capture on rising edge, frame bytes into command or data
	always_ff @(posedge sclk_i) begin
		if (!rst_sync_n) begin
			link_state <= sprf_pkg::LINK_CMD;
			bit_cnt <= 3'h0;
			in_shift <= 8'h00;
			sel <= 3'h0;
			wr_tgl <= 1'b0;
			wr_word <= 11'h000;
			rd_req_tgl <= 1'b0;
		end else if (csn_i) begin
			// deselected edges realign the count, next bit starts a command
			link_state <= sprf_pkg::LINK_CMD;
			bit_cnt <= 3'h0;
		end else begin
			in_shift <= next_byte;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				case (link_state)
					sprf_pkg::LINK_CMD: begin
						sel <= next_byte[2:0];
						if (next_byte[sprf_pkg::CMD_READ_BIT]) begin
							link_state <= sprf_pkg::LINK_READ;
							rd_req_tgl <= ~rd_req_tgl;
						end else begin
							link_state <= sprf_pkg::LINK_WRITE;
						end
					end
					sprf_pkg::LINK_WRITE: begin
						wr_word <= {sel, next_byte};
						wr_tgl <= ~wr_tgl;
						link_state <= sprf_pkg::LINK_CMD;
					end
					default: begin
						link_state <= sprf_pkg::LINK_CMD;
					end
				endcase
			end
		end
	end

	// serial side reset follows system reset through two flops; the host
	// must give two serial clock edges after release before its first frame
	always_ff @(posedge sclk_i) begin
		rst_sync_m <= rst_n_i;
		rst_sync_n <= rst_sync_m;
	end

	// register snapshot crosses as stable words, read well after update
	always_ff @(posedge sclk_i) begin
		for (int i = 0; i < sprf_pkg::REG_COUNT; i++) begin
			snap[i] <= regs[i];
		end
	end

	// output shifter loads the addressed register, shifts on falling
	always_ff @(negedge sclk_i) begin
		if (link_state == sprf_pkg::LINK_READ && bit_cnt == 3'h0) begin
			out_shift <= {snap[sel][6:0], 1'b0};
			dout_bit <= snap[sel][7];
		end else begin
			dout_bit <= out_shift[7];
			out_shift <= {out_shift[6:0], 1'b0};
		end
	end

	// system domain: synchronise pins and toggles
	logic [2:0] wr_tgl_s;
	logic [2:0] rd_tgl_s;
	logic [1:0] fault_s;
	logic wr_pulse;
	logic rd_pulse;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_tgl_s <= 3'h0;
			rd_tgl_s <= 3'h0;
			fault_s <= 2'h3;
		end else begin
			wr_tgl_s <= {wr_tgl_s[1:0], wr_tgl};
			rd_tgl_s <= {rd_tgl_s[1:0], rd_req_tgl};
			fault_s <= {fault_s[0], fault_pin_i};
		end
	end
	// each toggle is one request, seen as a single pulse in this domain
	assign wr_pulse = wr_tgl_s[2] ^ wr_tgl_s[1];
	assign rd_pulse = rd_tgl_s[2] ^ rd_tgl_s[1];

	// written words pass through the fifo before reaching the registers
	logic [10:0] wr_word_hold;
	logic fifo_out_valid;
	logic fifo_in_ready;
	logic [10:0] fifo_out_data;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_word_hold <= 11'h000;
		end else if (wr_pulse) begin
			wr_word_hold <= wr_word;
		end
	end
	logic push;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			push <= 1'b0;
		end else begin
			push <= wr_pulse || (push && !fifo_in_ready);
		end
	end
	sprf_fifo #(
		.WIDTH(11),
		.DEPTH(sprf_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(wr_word_hold),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(1'b1),
		.out_data_o(fifo_out_data)
	);

	// control registers written from the fifo
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < sprf_pkg::REG_COUNT; i++) begin
				regs[i] <= 8'h00;
			end
			regs[sprf_pkg::MODE_INDEX] <= sprf_pkg::MODE_RESET;
			regs[sprf_pkg::IOCTL_INDEX] <= sprf_pkg::IOCTL_RESET;
		end else begin
			if (fifo_out_valid && fifo_out_data[10:8] != sprf_pkg::STATUS_INDEX
				&& fifo_out_data[10:8] != sprf_pkg::DATA_INDEX) begin
				regs[fifo_out_data[10:8]] <= fifo_out_data[7:0];
			end
			regs[sprf_pkg::STATUS_INDEX] <= status_reg;
			if (conv_done_i) begin
				regs[sprf_pkg::DATA_INDEX] <= conv_data_i;
			end
		end
	end

	// fault pin mode, only one legal mode at a time
	sprf_pkg::sprf_fault_mode_type fault_mode;
	always_comb begin
		case (regs[sprf_pkg::IOCTL_INDEX][1:0])
			2'h1: fault_mode = sprf_pkg::FAULT_OPEN_DRAIN;
			2'h2: fault_mode = sprf_pkg::FAULT_DRIVEN;
			default: fault_mode = sprf_pkg::FAULT_INPUT;
		endcase
	end

	// external fault latch: a low pin in input mode sets it until reset
	logic ext_fault_set;
	assign ext_fault_set = (fault_mode == sprf_pkg::FAULT_INPUT)
		&& !fault_s[1];
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ext_fault <= 1'b0;
		end else if (ext_fault_set) begin
			ext_fault <= 1'b1;
		end
	end

	// status flags; the fault bit shares its place with an error flag
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			status_reg <= sprf_pkg::STATUS_RESET;
		end else begin
			status_reg[6:4] <= error_flags_i;
			// latched or just seen, so the flag shows three cycles after the pin, one after its synchroniser
			status_reg[sprf_pkg::STATUS_EXT_FAULT_BIT] <=
				error_flags_i[1] | ext_fault | ext_fault_set;
			status_reg[7] <= ready_n;
		end
	end
	assign status_o = status_reg;

	// ready indicator: low on new result, high again on read or at update
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ready_n <= 1'b1;
		end else if (conv_done_i) begin
			ready_n <= 1'b0;
		end else if (rd_pulse) begin
			ready_n <= 1'b1;
		end
	end
	// one cycle high at each update when unread
	logic ready_out_n;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ready_out_n <= 1'b1;
		end else begin
			ready_out_n <= ready_n | conv_done_i;
		end
	end

	// data/ready pin: tristate while deselected
	assign dout_oe_o = !csn_i;
	assign dout_o = (link_state == sprf_pkg::LINK_READ) ? dout_bit
		: ready_out_n;

	// fault pin drivers per mode
	logic any_error;
	assign any_error = |(status_reg & sprf_pkg::STATUS_ERROR_MASK);
	always_comb begin
		case (fault_mode)
			sprf_pkg::FAULT_OPEN_DRAIN: begin
				fault_pin_o = 1'b0;
				fault_pin_oe_o = any_error;
			end
			sprf_pkg::FAULT_DRIVEN: begin
				fault_pin_o = regs[sprf_pkg::IOCTL_INDEX]
					[sprf_pkg::IOCTL_FAULT_LEVEL_BIT];
				fault_pin_oe_o = 1'b1;
			end
			default: begin
				fault_pin_o = 1'b0;
				fault_pin_oe_o = 1'b0;
			end
		endcase
	end

	// switch and clock pin role
	assign power_down_switch_control_o =
		regs[sprf_pkg::IOCTL_INDEX][sprf_pkg::IOCTL_POWER_DOWN_SWITCH_CONTROL_BIT];
	assign clock_pin_role_o =
		regs[sprf_pkg::MODE_INDEX][sprf_pkg::MODE_CLKSEL_LSB +: 2];

	// fault pin checks for every mode, then the data pin tristate check
	AST_OD_NEVER_HIGH: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(fault_mode == sprf_pkg::FAULT_OPEN_DRAIN) |-> !fault_pin_o)
		else $error("open-drain fault pin driven high");
	AST_DRIVEN_FOLLOWS: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(fault_mode == sprf_pkg::FAULT_DRIVEN) |-> fault_pin_oe_o
		&& fault_pin_o == regs[sprf_pkg::IOCTL_INDEX]
		[sprf_pkg::IOCTL_FAULT_LEVEL_BIT])
		else $error("driven fault pin mismatch");
	AST_OD_ERROR: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(fault_mode == sprf_pkg::FAULT_OPEN_DRAIN && any_error)
		|-> fault_pin_oe_o)
		else $error("error not shown on fault pin");
	AST_INPUT_RELEASED: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(fault_mode == sprf_pkg::FAULT_INPUT) |-> !fault_pin_oe_o)
		else $error("fault pin driven in input mode");
	AST_EXT_FAULT: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(fault_mode == sprf_pkg::FAULT_INPUT && !fault_s[1]) |=>
		status_reg[sprf_pkg::STATUS_EXT_FAULT_BIT])
		else $error("external fault not flagged");
	AST_TRISTATE: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		csn_i |-> !dout_oe_o)
		else $error("data pin driven while deselected");
	// ready pin: low after a lone result, high at each update; then read clear and switch checks
	sequence seq_result_pulse;
		conv_done_i ##1 !conv_done_i;
	endsequence
	AST_READY_LOW: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_result_pulse |=> !ready_out_n)
		else $error("ready not low after result");
	AST_READY_GAP: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		conv_done_i |=> ready_out_n)
		else $error("ready not raised at update");
	AST_READ_CLEARS: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		rd_pulse && !conv_done_i |=> ready_n)
		else $error("ready not cleared by read");
	AST_POWER_DOWN_SWITCH_CONTROL: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$changed(power_down_switch_control_o) |->
		$past(fifo_out_valid))
		else $error("switch moved without a register write");
endmodule // sprf_top
`default_nettype wire

// [sprf_host.sv]
// host model driving the serial link of the port block
// assumes the device shifts dout after sclk falls and samples din on rise
`timescale 1ns/10ps
`default_nettype none
module sprf_host #(
	parameter real HALF_NS = 7.5
) (
	output logic sclk_o,
	output logic csn_o,
	output logic din_o,
	input wire logic dout_i
);
	// idle: serial clock high and still, device deselected
	initial begin
		sclk_o = 1'b1;
		csn_o = 1'b1;
		din_o = 1'b0;
	end
	// clock edges with chip select high, used while reset is held and just after release
	task automatic idle_clocks(input int n);
		repeat (n) begin
			#(HALF_NS) sclk_o = 1'b0;
			#(HALF_NS) sclk_o = 1'b1;
		end
	endtask
	// one frame: command byte then data byte, msb first
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat,
		input bit three_wire, output logic [7:0] rdat);
		logic [15:0] sh;
		sh = {cmd, wdat};
		csn_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#(HALF_NS) sclk_o = 1'b0;
			din_o = sh[i]; // set up before the rise
			#(HALF_NS);
			if (i < 8)
				rdat[i] = dout_i; // taken as the clock rises
			sclk_o = 1'b1;
		end
		#(HALF_NS) din_o = ~din_o; // released line shows no stale bit
		if (!three_wire)
			csn_o = 1'b1; // chip select stays low only in three-wire mode
	endtask
endmodule // sprf_host
`default_nettype wire

// [sprf_top_tb_top.sv]
// self-checking bench for the serial port, ready and fault pin block
// assumes the host model in sprf_host.sv owns the serial link
`timescale 1ns/10ps
`default_nettype none
module sprf_top_tb_top;
	logic clk, rst_n, sclk, csn, din, dout, dout_oe, fault_i, fault_o;
	logic fault_oe, ext_low, conv_done, sw, seen, dout_pin;
	logic [7:0] conv_data, status, rd;
	logic [2:0] errs;
	logic [1:0] role;
	int n_fail, checks, cycles;
	// fault wire: pull-up, low if anyone pulls it down
	assign fault_i = !((fault_oe && !fault_o) || ext_low);
	// data pin as the host sees it: a released line shows no stale level
	assign dout_pin = dout_oe ? dout : !dout;
	sprf_top i_sprf_top (.clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk),
		.csn_i(csn), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
		.fault_pin_i(fault_i), .fault_pin_o(fault_o),
		.fault_pin_oe_o(fault_oe), .conv_done_i(conv_done),
		.conv_data_i(conv_data), .error_flags_i(errs),
		.power_down_switch_control_o(sw), .clock_pin_role_o(role),
		.status_o(status));
	sprf_host #(.HALF_NS(7.5)) i_sprf_host (.sclk_o(sclk), .csn_o(csn),
		.din_o(din), .dout_i(dout_pin));
	// system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// compare and count
	task automatic check(input string nm, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// register write or read, then let the update land
	task automatic wr(input logic [2:0] a, input logic [7:0] v, input bit w3);
		i_sprf_host.frame({5'h00, a}, v, w3, rd);
		tick(10);
	endtask
	task automatic rdreg(input logic [2:0] a, input bit w3);
		i_sprf_host.frame({5'h08, a}, 8'h00, w3, rd);
		tick(10);
	endtask
	task automatic t_regs();
		wr(sprf_pkg::IOCTL_INDEX, 8'h08, 1'b0);
		check("switch", 8'(sw), 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(sprf_pkg::MODE_INDEX, 8'(k << 2), 1'b0);
			check("clock role", 8'(role), 8'(k));
		end
		rdreg(sprf_pkg::MODE_INDEX, 1'b0);
		check("mode readback", rd, 8'h0c);
		wr(sprf_pkg::IOCTL_INDEX, 8'h00, 1'b1);
		check("switch 3-wire", 8'(sw), 8'h00);
	endtask
	task automatic t_fault();
		wr(sprf_pkg::IOCTL_INDEX, 8'h06, 1'b0);
		check("gp high", {6'h00, fault_oe, fault_o}, 8'h03);
		wr(sprf_pkg::IOCTL_INDEX, 8'h02, 1'b0);
		check("gp low", {6'h00, fault_oe, fault_o}, 8'h02);
		wr(sprf_pkg::IOCTL_INDEX, 8'h05, 1'b0);
		check("od idle", 8'(fault_oe), 8'h00);
		errs = 3'h4;
		tick(6);
		check("od pull", {6'h00, fault_oe, fault_o}, 8'h02);
		errs = 3'h0;
		wr(sprf_pkg::IOCTL_INDEX, 8'h04, 1'b0);
		ext_low = 1'b1;
		tick(6);
		ext_low = 1'b0;
		tick(6);
		check("input mode oe", 8'(fault_oe), 8'h00);
		check("ext fault", 8'(status[5]), 8'h01);
	endtask
	task automatic pulse(input logic [7:0] d);
		conv_data = d;
		conv_done = 1'b1;
		tick(1);
		conv_done = 1'b0;
	endtask
	task automatic t_ready();
		wr(sprf_pkg::MODE_INDEX, 8'h00, 1'b1);
		pulse(8'ha5);
		tick(6);
		check("ready low", {6'h00, dout_oe, dout}, 8'h02);
		seen = 1'b0;
		pulse(8'h3c);
		for (int i = 0; i < 8; i++) begin
			if (dout === 1'b1)
				seen = 1'b1;
			tick(1);
		end
		check("ready high at update", 8'(seen), 8'h01);
		check("ready low again", 8'(dout), 8'h00);
		rdreg(sprf_pkg::DATA_INDEX, 1'b0);
		check("data read", rd, 8'h3c);
		check("ready cleared by read", 8'(status[7]), 8'h01);
		check("deselected", 8'(dout_oe), 8'h00);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		conv_done = 1'b0;
		conv_data = 8'h00;
		errs = 3'h0;
		ext_low = 1'b0;
		fork
			i_sprf_host.idle_clocks(4);
			tick(6);
		join
		rst_n = 1'b1;
		i_sprf_host.idle_clocks(3); // serial side leaves reset on sclk
		tick(2);
		check("reset pins", {4'h0, role, sw, fault_oe}, 8'h00);
		check("reset status", status, 8'h80);
		check("reset dout", 8'(dout_oe), 8'h00);
		t_regs();
		t_fault();
		t_ready();
		print_verdict();
	end
endmodule // sprf_top_tb_top
`default_nettype wire
